// ### rtl/dmo_cfg_top.sv
// demodulator override, gain and test-output configuration with spi write port
`timescale 1ns/1ps

module dmo_cfg_top #(
  parameter int NUM_UNITS     = 2,
  parameter int CH_PER_UNIT   = 4,
  parameter int FILT_W        = 36,
  parameter int OUT_W         = 16,
  parameter int NUM_LANES     = 4
) (
  input  wire logic                                    core_clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    ce,
  input  wire logic                                    spi_sclk,
  input  wire logic                                    spi_sen_n,
  input  wire logic                                    spi_sdata,
  input  wire logic                                    sample_valid,
  input  wire logic [NUM_UNITS*CH_PER_UNIT*FILT_W-1:0] filt_data,
  input  wire logic [OUT_W-1:0]                        coef_word,
  input  wire logic [2:0]                              prof_shift,
  input  wire logic [7:0]                              prof_coef_base,
  input  wire logic [5:0]                              prof_decim,
  input  wire logic [15:0]                             prof_mix_freq,
  output logic                                         out_valid,
  output logic      [NUM_UNITS*CH_PER_UNIT*OUT_W-1:0]  out_data,
  output logic      [2:0]                              eff_shift,
  output logic      [7:0]                              eff_coef_base,
  output logic      [5:0]                              eff_decim,
  output logic      [15:0]                             eff_mix_freq,
  output logic      [1:0]                              serializer_ratio,
  output logic      [2:0]                              output_res,
  output logic      [NUM_LANES*2-1:0]                  lane_mode,
  output logic      [NUM_LANES*2-1:0]                  lane_chan,
  output logic      [NUM_LANES-1:0]                    lane_pair
);

  localparam int NCH = NUM_UNITS * CH_PER_UNIT;

  // ****************************************************************
  // spi receiver on the link clock
  // ****************************************************************
  logic [dmo_pkg::SPI_FRAME_BITS-1:0] spi_shift;
  logic [4:0]                         spi_cnt;
  logic [dmo_pkg::SPI_FRAME_BITS-1:0] spi_word;
  logic                               spi_tgl;
  logic                               spi_clr_n;
  logic                               spi_done;

  // frame end clears the bit count without needing another sclk edge
  assign spi_clr_n = rst_n & ~spi_sen_n;
  assign spi_done  = (spi_cnt == dmo_pkg::SPI_LAST_BIT);

  // bit counter, msb-first shift, address then data
  always_ff @(posedge spi_sclk or negedge spi_clr_n) begin
    if (!spi_clr_n) begin
      spi_cnt <= 5'h00;
    end else begin
      spi_cnt <= spi_done ? 5'h00 : spi_cnt + 5'h01;
    end
  end

  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_shift <= '0;
    end else if (!spi_sen_n) begin
      spi_shift <= {spi_shift[dmo_pkg::SPI_FRAME_BITS-2:0], spi_sdata};
    end
  end

  // word held stable for a whole frame after its toggle
  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_word <= '0;
      spi_tgl  <= 1'b0;
    end else if (!spi_sen_n && spi_done) begin
      spi_word <= {spi_shift[dmo_pkg::SPI_FRAME_BITS-2:0], spi_sdata};
      spi_tgl  <= ~spi_tgl;
    end
  end

  // ****************************************************************
  // crossing into the core clock
  // ****************************************************************
  logic        tgl_sync;
  logic        tgl_seen;
  logic        wr_pulse;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;

  dmo_sync #(
    .W (1)
  ) u_tgl_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .d        (spi_tgl),
    .q        (tgl_sync)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_seen <= 1'b0;
    end else if (ce) begin
      tgl_seen <= tgl_sync;
    end
  end

  // word is quiet by the time the toggle arrives
  assign wr_pulse = ce & (tgl_sync ^ tgl_seen);
  assign wr_addr  = spi_word[dmo_pkg::SPI_FRAME_BITS-1:dmo_pkg::DATA_W];
  assign wr_data  = spi_word[dmo_pkg::DATA_W-1:0];

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0] out_format;
  logic [15:0] demod_ctrl;
  logic [15:0] decim_gain_test_ctrl;
  logic [15:0] test_tone_cfg;
  logic [15:0] coef_decim_override;
  logic [15:0] mix_freq_override_enable;
  logic [15:0] mix_freq_override_value;

  // address decode
  wire wr_fmt  = wr_pulse && (wr_addr == dmo_pkg::ADDR_OUT_FORMAT);
  wire wr_ctrl = wr_pulse && (wr_addr == dmo_pkg::ADDR_DEMOD_CTRL);
  wire wr_dgt  = wr_pulse && (wr_addr == dmo_pkg::ADDR_DECIM_GAIN);
  wire wr_tone = wr_pulse && (wr_addr == dmo_pkg::ADDR_TONE_CFG);
  wire wr_cdo  = wr_pulse && (wr_addr == dmo_pkg::ADDR_COEF_DECIM);
  wire wr_mxe  = wr_pulse && (wr_addr == dmo_pkg::ADDR_MIX_EN);
  wire wr_mxv  = wr_pulse && (wr_addr == dmo_pkg::ADDR_MIX_VAL);

  // unmapped addresses are dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_format               <= dmo_pkg::OUT_FORMAT_RST;
      demod_ctrl               <= dmo_pkg::DEMOD_CTRL_RST;
      decim_gain_test_ctrl     <= dmo_pkg::ZERO_RST;
      test_tone_cfg            <= dmo_pkg::ZERO_RST;
      coef_decim_override      <= dmo_pkg::ZERO_RST;
      mix_freq_override_enable <= dmo_pkg::ZERO_RST;
      mix_freq_override_value  <= dmo_pkg::ZERO_RST;
    end else begin
      if (wr_fmt)  out_format <= wr_data;
      if (wr_ctrl) demod_ctrl <= wr_data;
      if (wr_dgt)  decim_gain_test_ctrl <= wr_data & dmo_pkg::DECIM_GAIN_MASK;
      if (wr_tone) test_tone_cfg <= wr_data;
      if (wr_cdo)  coef_decim_override <= wr_data;
      if (wr_mxe)  mix_freq_override_enable <= wr_data;
      if (wr_mxv)  mix_freq_override_value <= wr_data;
    end
  end

  // ****************************************************************
  // field extraction
  // ****************************************************************
  wire       output_shift_override_on = decim_gain_test_ctrl[dmo_pkg::BIT_SHIFT_OVR];
  wire [2:0] output_shift_amount      = decim_gain_test_ctrl[dmo_pkg::SHIFT_LSB +: 3];
  wire       coef_dump_test_on        = decim_gain_test_ctrl[dmo_pkg::BIT_COEF_DUMP];
  wire       tone_test_on             = decim_gain_test_ctrl[dmo_pkg::BIT_TONE_ON];
  wire [6:0] tone_offset              = test_tone_cfg[dmo_pkg::TONE_DC_LSB +: 7];
  wire [3:0] tone_level               = test_tone_cfg[dmo_pkg::TONE_LVL_LSB +: 4];
  wire [4:0] tone_freq_step           = test_tone_cfg[dmo_pkg::TONE_STEP_LSB +: 5];
  wire       coef_base_override_on    = coef_decim_override[dmo_pkg::BIT_COEF_OVR];
  wire [7:0] coef_base_value          = coef_decim_override[dmo_pkg::COEF_LSB +: 8];
  wire       decim_ratio_override_on  = coef_decim_override[dmo_pkg::BIT_DECIM_OVR];
  wire [5:0] decim_ratio_value        = coef_decim_override[dmo_pkg::DECIM_LSB +: 6];
  wire       mix_freq_override_on     = mix_freq_override_enable[dmo_pkg::BIT_MIX_OVR];
  wire       extra_gain_12db          = demod_ctrl[dmo_pkg::BIT_EXTRA_GAIN];
  wire       mod_bypass               = demod_ctrl[dmo_pkg::BIT_MOD_BYPASS];
  wire       ch_swap                  = demod_ctrl[dmo_pkg::BIT_CH_SWAP];
  wire       full_lanes               = demod_ctrl[dmo_pkg::BIT_FULL_LANES];

  // ****************************************************************
  // profile versus register selection
  // ****************************************************************
  logic [5:0] decim_clamped;
  logic [2:0] next_shift;
  logic [5:0] next_decim;

  // out-of-range manual factors are pinned to the legal span
  assign decim_clamped = (decim_ratio_value < dmo_pkg::DECIM_MIN) ? dmo_pkg::DECIM_MIN :
                         (decim_ratio_value > dmo_pkg::DECIM_MAX) ? dmo_pkg::DECIM_MAX :
                         decim_ratio_value;
  assign next_shift = output_shift_override_on ? output_shift_amount : prof_shift;
  assign next_decim = decim_ratio_override_on ? decim_clamped : prof_decim;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_shift     <= 3'h0;
      eff_coef_base <= 8'h00;
      eff_decim     <= dmo_pkg::DECIM_MIN;
      eff_mix_freq  <= 16'h0000;
    end else if (ce) begin
      eff_shift     <= next_shift;
      eff_coef_base <= coef_base_override_on ? coef_base_value : prof_coef_base;
      eff_decim     <= next_decim;
      eff_mix_freq  <= mix_freq_override_on ? mix_freq_override_value
                                            : prof_mix_freq;
    end
  end

  // serializer and resolution fields go straight to the lvds framer
  assign serializer_ratio = out_format[dmo_pkg::SERZ_LSB +: 2];
  assign output_res       = out_format[dmo_pkg::RES_LSB +: 3];

  // ****************************************************************
  // test tone
  // ****************************************************************
  logic signed [dmo_pkg::TONE_W-1:0] tone;

  dmo_tone_gen u_tone (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .advance  (sample_valid),
    .step     (tone_freq_step),
    .level    (tone_level),
    .offset   (tone_offset),
    .tone     (tone)
  );

  // ****************************************************************
  // per-channel gain, saturation and output select
  // ****************************************************************
  logic [5:0]        rshift;
  logic [OUT_W-1:0]  sat_hi;
  logic [FILT_W-1:0] lim_hi;
  logic [FILT_W-1:0] lim_lo;

  // the 12 dB step is two fewer shift bits
  assign rshift = dmo_pkg::SHIFT_BASE - {3'h0, eff_shift}
                  - (extra_gain_12db ? dmo_pkg::GAIN_12DB_SHIFT : 6'h00);
  assign sat_hi = (output_res == dmo_pkg::RES_16BIT) ? dmo_pkg::SAT16_HI : dmo_pkg::SAT14_HI;
  assign lim_hi = {{(FILT_W-OUT_W){1'b0}}, sat_hi};
  assign lim_lo = ~lim_hi;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      wire signed [FILT_W-1:0] f_in   = filt_data[c*FILT_W +: FILT_W];
      wire signed [FILT_W-1:0] f_sh   = f_in >>> rshift;
      wire                     over   = f_sh > $signed(lim_hi);
      wire                     under  = f_sh < $signed(lim_lo);
      wire        [OUT_W-1:0]  f_sat  = over ? lim_hi[OUT_W-1:0] :
                                        under ? lim_lo[OUT_W-1:0] : f_sh[OUT_W-1:0];
      wire        [OUT_W-1:0]  tone_x = {{(OUT_W-dmo_pkg::TONE_W){tone[dmo_pkg::TONE_W-1]}},
                                         tone};
      // coefficient dump outranks the tone when both are on
      wire        [OUT_W-1:0]  next_q = coef_dump_test_on ? coef_word :
                                        tone_test_on ? tone_x : f_sat;

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          out_data[c*OUT_W +: OUT_W] <= '0;
        end else if (ce && sample_valid) begin
          out_data[c*OUT_W +: OUT_W] <= next_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
    end else if (ce) begin
      out_valid <= sample_valid;
    end
  end

  // ****************************************************************
  // lane assignment
  // ****************************************************************
  wire decim_one  = (eff_decim == dmo_pkg::DECIM_MIN);
  wire pair_lanes = !full_lanes && (eff_decim >= dmo_pkg::PAIR_MIN_DECIM);

  genvar l;
  generate
    for (l = 0; l < NUM_LANES; l++) begin : g_lane
      localparam logic [1:0] LIDX = 2'(l);
      // bypass: lane pair shares one channel, i then q
      wire [1:0] byp_chan = {LIDX[1], ch_swap};
      wire [1:0] iq_chan  = {LIDX[1], LIDX[0] ^ ch_swap};
      wire [1:0] next_mode = mod_bypass ? (LIDX[0] ? dmo_pkg::LANE_Q : dmo_pkg::LANE_I) :
                             decim_one ? dmo_pkg::LANE_I :
                             (pair_lanes && LIDX[0]) ? dmo_pkg::LANE_IDLE :
                             dmo_pkg::LANE_IQ;
      wire [1:0] next_chan = mod_bypass ? byp_chan : iq_chan;
      wire       next_pair = !mod_bypass && !decim_one && pair_lanes && !LIDX[0];

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          lane_mode[l*2 +: 2] <= dmo_pkg::LANE_IQ;
          lane_chan[l*2 +: 2] <= LIDX;
          lane_pair[l]        <= 1'b0;
        end else if (ce) begin
          lane_mode[l*2 +: 2] <= next_mode;
          lane_chan[l*2 +: 2] <= next_chan;
          lane_pair[l]        <= next_pair;
        end
      end
    end
  endgenerate

endmodule

// ### rtl/dmo_pkg.sv
// package: register map, field layout and fixed constants of the demod config block
package dmo_pkg;

  // ****************************************************************
  // spi frame
  // ****************************************************************
  localparam int ADDR_W          = 8;
  localparam int DATA_W          = 16;
  localparam int SPI_FRAME_BITS  = ADDR_W + DATA_W;
  localparam logic [4:0] SPI_LAST_BIT = 5'h17;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_OUT_FORMAT  = 8'h03;
  localparam logic [7:0] ADDR_DEMOD_CTRL  = 8'h0a;
  localparam logic [7:0] ADDR_DECIM_GAIN  = 8'h1d;
  localparam logic [7:0] ADDR_TONE_CFG    = 8'h1e;
  localparam logic [7:0] ADDR_COEF_DECIM  = 8'h1f;
  localparam logic [7:0] ADDR_MIX_EN      = 8'h20;
  localparam logic [7:0] ADDR_MIX_VAL     = 8'h21;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] OUT_FORMAT_RST = 16'h2000;  // serializer 16x, 14-bit output
  localparam logic [15:0] DEMOD_CTRL_RST = 16'h1402;
  localparam logic [15:0] ZERO_RST       = 16'h0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_SHIFT_OVR  = 7;
  localparam int SHIFT_LSB      = 4;
  localparam int BIT_COEF_DUMP  = 3;
  localparam int BIT_TONE_ON    = 2;
  localparam logic [15:0] DECIM_GAIN_MASK = 16'hfffc;  // reserved low bits held at zero
  localparam int TONE_DC_LSB    = 9;
  localparam int TONE_LVL_LSB   = 5;
  localparam int TONE_STEP_LSB  = 0;
  localparam int BIT_COEF_OVR   = 15;
  localparam int COEF_LSB       = 7;
  localparam int BIT_DECIM_OVR  = 6;
  localparam int DECIM_LSB      = 0;
  localparam int BIT_MIX_OVR    = 0;
  localparam int BIT_MOD_BYPASS = 14;
  localparam int BIT_EXTRA_GAIN = 13;
  localparam int BIT_CH_SWAP    = 11;
  localparam int BIT_FULL_LANES = 9;
  localparam int SERZ_LSB       = 13;
  localparam int RES_LSB        = 9;

  // ****************************************************************
  // arithmetic constants
  // ****************************************************************
  localparam logic [5:0] SHIFT_BASE      = 6'h14;  // twenty
  localparam logic [5:0] GAIN_12DB_SHIFT = 6'h02;  // x4
  localparam logic [5:0] DECIM_MIN       = 6'h01;
  localparam logic [5:0] DECIM_MAX       = 6'h20;
  localparam logic [5:0] PAIR_MIN_DECIM  = 6'h04;
  localparam logic [2:0] RES_16BIT       = 3'h1;
  localparam logic [15:0] SAT14_HI       = 16'h1fff;
  localparam logic [15:0] SAT16_HI       = 16'h7fff;
  localparam int TONE_W = 14;
  localparam logic [3:0] TONE_FULL_LVL   = 4'he;

  // ****************************************************************
  // lane content modes
  // ****************************************************************
  typedef enum logic [1:0] {
    LANE_IQ   = 2'h0,
    LANE_I    = 2'h1,
    LANE_Q    = 2'h2,
    LANE_IDLE = 2'h3
  } dmo_lane_t;

endpackage

// ### rtl/dmo_sync.sv
// two-flop level synchroniser with clock enable
`timescale 1ns/1ps
module dmo_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### rtl/dmo_tone_gen.sv
// synthetic test sine: 64-step phase, power-of-two level, dc offset
`timescale 1ns/1ps
module dmo_tone_gen (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         advance,
  input  wire logic [4:0]                   step,
  input  wire logic [3:0]                   level,
  input  wire logic [6:0]                   offset,
  output logic signed [dmo_pkg::TONE_W-1:0] tone
);

  logic        [5:0]  phase;
  logic        [4:0]  tab_idx;
  logic        [12:0] mag;
  logic signed [14:0] wave;
  logic signed [14:0] scaled;
  logic        [3:0]  rsh;
  logic signed [14:0] sum;
  logic signed [13:0] next_tone;

  // quarter-wave table, 13-bit magnitude
  function automatic logic [12:0] quarter(input logic [4:0] i);
    case (i)
      5'h00: quarter = 13'h0000;
      5'h01: quarter = 13'h0323;
      5'h02: quarter = 13'h063e;
      5'h03: quarter = 13'h094a;
      5'h04: quarter = 13'h0c3f;
      5'h05: quarter = 13'h0f15;
      5'h06: quarter = 13'h11c7;
      5'h07: quarter = 13'h144c;
      5'h08: quarter = 13'h16a0;
      5'h09: quarter = 13'h18bc;
      5'h0a: quarter = 13'h1a9b;
      5'h0b: quarter = 13'h1c38;
      5'h0c: quarter = 13'h1d90;
      5'h0d: quarter = 13'h1e9e;
      5'h0e: quarter = 13'h1f62;
      5'h0f: quarter = 13'h1fd8;
      default: quarter = 13'h1fff;
    endcase
  endfunction

  // fold the 64-step phase into a quarter wave
  assign tab_idx = phase[4] ? 5'h10 - {1'b0, phase[3:0]} : {1'b0, phase[3:0]};
  assign mag     = quarter(tab_idx);
  assign wave    = phase[5] ? -$signed({2'b00, mag}) : $signed({2'b00, mag});

  // level 0 gives dc only, 14 and above is full scale
  assign rsh    = (level >= dmo_pkg::TONE_FULL_LVL) ? 4'h0 : dmo_pkg::TONE_FULL_LVL - level;
  assign scaled = (level == 4'h0) ? 15'sh0000 : (wave >>> rsh);
  assign sum    = scaled + {{8{offset[6]}}, offset};

  // saturate the offset tone to 14 bits
  assign next_tone = (sum > 15'sh1fff) ? 14'sh1fff :
                     (sum < -15'sh2000) ? -14'sh2000 : sum[13:0];

  // phase steps by fs/64 units per sample
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 6'h00;
      tone  <= 14'sh0000;
    end else if (ce && advance) begin
      phase <= phase + {1'b0, step};
      tone  <= next_tone;
    end
  end

endmodule

// ### test/dmo_cfg_asserts.sv
// checker: port-level timing and relation checks of the demod config block
`timescale 1ns/1ps
module dmo_cfg_asserts #(
  parameter int NUM_UNITS   = 2,
  parameter int CH_PER_UNIT = 4,
  parameter int OUT_W       = 16,
  parameter int NUM_LANES   = 4
) (
  input wire logic                                   core_clk,
  input wire logic                                   rst_n,
  input wire logic                                   ce,
  input wire logic                                   spi_sen_n,
  input wire logic                                   sample_valid,
  input wire logic [2:0]                             prof_shift,
  input wire logic [15:0]                            prof_mix_freq,
  input wire logic                                   out_valid,
  input wire logic [NUM_UNITS*CH_PER_UNIT*OUT_W-1:0] out_data,
  input wire logic [2:0]                             eff_shift,
  input wire logic [5:0]                             eff_decim,
  input wire logic [15:0]                            eff_mix_freq,
  input wire logic [1:0]                             serializer_ratio,
  input wire logic [2:0]                             output_res,
  input wire logic [NUM_LANES*2-1:0]                 lane_mode,
  input wire logic [NUM_LANES-1:0]                   lane_pair
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // properties
  // ****************************************************************
  // no write can land while select has been high this long
  sequence quiet_bus;
    spi_sen_n [*6];
  endsequence
  out_valid_a: assert property (sample_valid && ce |=> out_valid)
    else $error("sample not answered");
  out_hold_a: assert property (!sample_valid && ce |=> $stable(out_data) && !out_valid)
    else $error("output moved without sample");
  reset_vals_a: assert property (disable iff (1'b0) !rst_n [*2] |->
    serializer_ratio == 2'h1 && output_res == 3'h0 && eff_decim == 6'h01)
    else $error("bad reset outputs");
  decim_range_a: assert property (eff_decim >= 6'h01 && eff_decim <= 6'h20)
    else $error("decimation out of range");
  pair_decim_a: assert property (|lane_pair |-> eff_decim >= 6'h04 || $past(eff_decim) >= 6'h04)
    else $error("pairing with low decimation");
  pair_idle_a: assert property (lane_pair[0] |-> lane_mode[3:2] == dmo_pkg::LANE_IDLE)
    else $error("odd lane not idle");
  mix_quiet_a: assert property (quiet_bus ##0 $stable(prof_mix_freq) |=> $stable(eff_mix_freq))
    else $error("mix frequency moved");
  shift_quiet_a: assert property (quiet_bus ##0 $stable(prof_shift) [*2] |-> $stable(eff_shift))
    else $error("shift moved");
endmodule

bind dmo_cfg_top dmo_cfg_asserts #(.NUM_UNITS(NUM_UNITS), .CH_PER_UNIT(CH_PER_UNIT),
  .OUT_W(OUT_W), .NUM_LANES(NUM_LANES)) dmo_cfg_asserts_inst (.core_clk, .rst_n, .ce,
  .spi_sen_n, .sample_valid, .prof_shift, .prof_mix_freq, .out_valid, .out_data, .eff_shift,
  .eff_decim, .eff_mix_freq, .serializer_ratio, .output_res, .lane_mode, .lane_pair);

// ### test/dmo_spi_host.sv
// behavioural spi host: 24-bit write frames on its own 80 ns link clock
`timescale 1ns/1ps
module dmo_spi_host (
  output logic spi_sclk,
  output logic spi_sen_n,
  output logic spi_sdata
);
  initial begin
    spi_sclk = 1'b0;
    spi_sen_n = 1'b1;
    spi_sdata = 1'b1;
  end
  // one frame msb first; clock stands still between frames
  task automatic write(input logic [7:0] addr, input logic [15:0] data);
    logic [23:0] word;
    word = {addr, (addr == dmo_pkg::ADDR_DECIM_GAIN) ? data & dmo_pkg::DECIM_GAIN_MASK : data};
    #3.3 spi_sen_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdata = word[i];
      #40 spi_sclk = 1'b1;
      #40 spi_sclk = 1'b0;
    end
    spi_sen_n = 1'b1;
    spi_sdata = ~word[0];  // released line must not look held
  endtask
endmodule

// ### test/testbench.sv
// self-checking bench: spi writes, overrides and a reference sample model
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
  logic         core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sample_valid = 1'b0;
  logic [287:0] filt_data = '0;
  logic [15:0]  coef_word = 16'h0000, prof_mix_freq = 16'h0000, eff_mix_freq, v;
  logic [2:0]   prof_shift = 3'h0, eff_shift, output_res;
  logic [7:0]   prof_coef_base = 8'h00, eff_coef_base, lane_mode, lane_chan, b;
  logic [5:0]   prof_decim = 6'h08, eff_decim, d;
  logic [127:0] out_data;
  logic [1:0]   serializer_ratio;
  logic [3:0]   lane_pair;
  logic [6:0]   dc;
  logic         spi_sclk, spi_sen_n, spi_sdata, out_valid;
  int           errors = 0, checked = 0, m_n = 0, m_gain = 0, m_res16 = 0, m_mode = 0, m_tone = 0;
  always #2.5 core_clk = ~core_clk;
  dmo_spi_host host_inst (.spi_sclk, .spi_sen_n, .spi_sdata);
  dmo_cfg_top dmo_cfg_top_inst (.core_clk, .rst_n, .ce, .spi_sclk, .spi_sen_n, .spi_sdata,
    .sample_valid, .filt_data, .coef_word, .prof_shift, .prof_coef_base, .prof_decim,
    .prof_mix_freq, .out_valid, .out_data, .eff_shift, .eff_coef_base, .eff_decim,
    .eff_mix_freq, .serializer_ratio, .output_res, .lane_mode, .lane_chan, .lane_pair);
  // reference word of one channel: test modes, else shift and saturation to -lim-1 .. lim
  function automatic logic [15:0] exp_out(input int c);
    longint r;
    longint lim;
    r = longint'($signed(filt_data[c*36 +: 36])) >>> (20 - m_n - 2 * m_gain);
    lim = m_res16 ? 32767 : 8191;
    if (m_mode == 1) return coef_word;
    if (m_mode == 2) return 16'(m_tone);
    return 16'((r > lim) ? lim : (r < -lim - 1) ? -lim - 1 : r);
  endfunction
  // one random sample, compared in the cycle out_valid stands
  task automatic sample(input bit chk);
    @(negedge core_clk);
    for (int c = 0; c < 8; c++) filt_data[c*36 +: 36] = 36'($signed($urandom()));
    coef_word = 16'($urandom());
    sample_valid = 1'b1;
    @(negedge core_clk);
    sample_valid = 1'b0;
    for (int c = 0; c < 8; c++) if (chk) `CHK(out_data[c*16 +: 16], exp_out(c), "word")
  endtask
  // a write needs sync plus two cycles before effective outputs follow
  task automatic send(input logic [7:0] a, input logic [15:0] dat);
    host_inst.write(a, dat);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hc449));
    prof_shift = 3'($urandom());
    prof_coef_base = 8'($urandom());
    prof_mix_freq = 16'($urandom());
    m_n = prof_shift;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    `CHK(serializer_ratio, 2'h1, "serializer")
    `CHK(output_res, 3'h0, "resolution")
    `CHK(eff_shift, prof_shift, "shift")
    `CHK(eff_coef_base, prof_coef_base, "base")
    `CHK(eff_decim, prof_decim, "decim")
    `CHK(eff_mix_freq, prof_mix_freq, "freq")
    repeat (4) sample(1'b1);
    `CHK({lane_pair[0], lane_mode[3:2]}, 3'h7, "pairing")
    $display("reset test done");
    for (int g = 0; g < 2; g++) begin
      send(dmo_pkg::ADDR_DEMOD_CTRL, 16'h1402 | 16'(g << 13));
      m_gain = g;
      for (int n = 0; n < 8; n++) begin
        send(dmo_pkg::ADDR_DECIM_GAIN, 16'h0083 | 16'(n << 4));
        m_n = n;
        `CHK(eff_shift, 3'(n), "forced shift")
        sample(1'b1);
      end
    end
    send(dmo_pkg::ADDR_OUT_FORMAT, 16'h2200);
    m_res16 = 1;
    `CHK({serializer_ratio, output_res}, 5'h09, "format")
    send(dmo_pkg::ADDR_OUT_FORMAT, 16'h4200);
    `CHK(serializer_ratio, 2'h2, "pass-through")
    repeat (4) sample(1'b1);
    $display("gain test done");
    send(dmo_pkg::ADDR_DEMOD_CTRL, 16'h3602);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom());
      d = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : (i == 2) ? 6'h20 : 6'h3f;
      send(dmo_pkg::ADDR_COEF_DECIM, {1'b1, b, 1'b1, d});
      prof_coef_base = ~b;
      prof_decim = 6'h02;
      @(negedge core_clk);
      `CHK(eff_coef_base, b, "forced base")
      `CHK(eff_decim, 6'((d == 0) ? 1 : (d > 32) ? 32 : d), "forced decim")
    end
    v = 16'($urandom());
    send(dmo_pkg::ADDR_MIX_VAL, v);
    `CHK(eff_mix_freq, prof_mix_freq, "freq idle")
    send(dmo_pkg::ADDR_MIX_EN, 16'h0001);
    send(8'h22, ~v);
    `CHK(eff_mix_freq, v, "forced freq")
    send(dmo_pkg::ADDR_COEF_DECIM, 16'h0000);
    `CHK(eff_decim, 6'h02, "decim back")
    $display("override test done");
    send(dmo_pkg::ADDR_DECIM_GAIN, 16'h000c);
    m_mode = 1;
    repeat (2) sample(1'b1);
    for (int i = 0; i < 2; i++) begin
      dc = i ? 7'h40 : 7'h3f;
      send(dmo_pkg::ADDR_TONE_CFG, {dc, 9'h000});
      send(dmo_pkg::ADDR_DECIM_GAIN, 16'h0004);
      m_mode = 2;
      m_tone = $signed(dc);
      sample(1'b0);
      sample(1'b1);
    end
    send(dmo_pkg::ADDR_TONE_CFG, 16'h01d0);
    for (int k = 0; k < 6; k++) begin
      m_tone = (k == 2) ? 8191 : (k == 4) ? -8191 : 0;
      sample(k > 0);
    end
    $display("test mode test done");
    finish_test();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    finish_test();
  end
endmodule
